// ### logic/ecsd_pkg.sv
/*
 Package for the edge-count setpoint decoder: timing constants,
 setpoint codes and the timeout-to-cycles derivation.
 Assumes a 100 MHz system clock.
*/
`default_nettype none
package ecsd_pkg;
   localparam int CLK_MHZ = 100;
   // Timeouts in microseconds
   localparam int LATCH_TIMEOUT_US = 500;
   localparam int OFF_TIMEOUT_US = 500;
   localparam int MAX_HIGH_TIME_US = 75;
   // Timeouts scale exactly to whole cycles at CLK_MHZ
   localparam int LATCH_TIMEOUT_CYC = LATCH_TIMEOUT_US * CLK_MHZ;
   localparam int OFF_TIMEOUT_CYC = OFF_TIMEOUT_US * CLK_MHZ;
   localparam int TIMER_W = 16;
   localparam int CODE_W = 4;
   // Code 0 = one edge = 0.60 V; each step adds 0.04 V up to 1.20 V
   localparam logic [3:0] DEFAULT_CODE = 4'h0;
   localparam logic [3:0] MAX_CODE = 4'hf;
   // Reference levels in millivolts: low reference base and step, and the high reference
   localparam logic [10:0] LOW_REF_BASE_MV = 11'h258;
   localparam logic [10:0] LOW_REF_STEP_MV = 11'h028;
   localparam logic [10:0] HIGH_REF_MV = 11'h4b0;
   typedef enum logic [1:0] {ECSD_OFF, ECSD_COUNT, ECSD_WAIT_LOW, ECSD_RUN} ecsd_state_t;
endpackage
`default_nettype wire

// ### logic/ecsd_timer.sv
/*
 Level-duration timer: counts cycles while a level holds and
 pulses expired once when the limit is reached.
 Assumes the level input is already synchronous to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module ecsd_timer #(
   parameter int LIMIT = 50000,
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Level to time
   input wire logic run_in,
   output logic expired_out
);
   logic [W-1:0] count;
   wire at_limit = (count == W'(LIMIT - 1));

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in || !run_in)
      begin
         count <= '0;
         expired_out <= 1'b0;
      end
      else
      begin
         // Saturate so the pulse happens once per qualifying level
         if (count != W'(LIMIT))
            count <= count + W'(1);
         expired_out <= at_limit;
      end
   end
endmodule
`default_nettype wire

// ### logic/ecsd_decoder.sv
/*
 Edge-count setpoint decoder for a boost regulator reference.
 Selects high or low feedback reference from ref_sel_in and programs
 one of 16 low-reference levels by counting rising edges on en_set_in.
 Assumes en_set_in and ref_sel_in are synchronous to clk_in; power-up
 is represented by sys_rst_in.
*/
// Functional notes
// RQ1: Select high enables the high reference at 1.2 V and turns the low reference off.
// RQ2: Select low enables the low reference at 0.6 V nominal and turns the high reference off.
// RQ3: The active reference follows every toggle of the select input during operation.
// RQ4: The host keeps select low for the whole time it programs by edge count.
// RQ5: Rising edges on the enable/set pin are counted and decoded into one of 16 levels.
// RQ6: The host sends programming edges no faster than 1 MHz.
// RQ7: After the last edge the pin stays high for the latch timeout, then the count is latched and applied.
// RQ8: The pin held low longer than the off timeout disables the device.
// RQ9: Entering the disabled state resets the setpoint to the 0.6 V default.
// RQ10: After power-up with select low and no programming the low reference is 0.6 V.
// RQ11: One edge maps to 0.60 V and each further edge adds 0.04 V, up to 1.20 V at 16 edges.
// RQ12: The host keeps each high phase between edges no longer than 75 us.
// RQ13: Both timeouts are internal timers that expire within 500 us of the qualifying level.
// RQ14: A rising edge after a disabled period enables the device and counts as the first edge.
`timescale 1ns/1ps
`default_nettype none
module ecsd_decoder #(
   parameter int LATCH_CYCLES = ecsd_pkg::LATCH_TIMEOUT_CYC,
   parameter int OFF_CYCLES = ecsd_pkg::OFF_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Pins from the host
   input wire logic en_set_in,
   input wire logic ref_sel_in,
   // Regulator control
   output logic enabled_out,
   output logic high_feedback_ref_en_out,
   output logic low_feedback_ref_en_out,
   output logic [3:0] setpoint_code_out,
   output logic [10:0] ref_mv_out
);
   // Control state
   ecsd_pkg::ecsd_state_t state;
   ecsd_pkg::ecsd_state_t next_state;
   // Pin history, burst count and the applied code
   logic en_set_d;
   logic [3:0] edge_count;
   logic [3:0] next_edge_count;
   logic [3:0] setpoint;
   logic [3:0] next_setpoint;
   // One-cycle pulses from the two level timers
   logic latch_hit;
   logic off_hit;

   // Low reference level of a code: base plus one step per code
   function automatic logic [10:0] code_to_mv(input logic [3:0] code);
      code_to_mv = ecsd_pkg::LOW_REF_BASE_MV + 11'(code) * ecsd_pkg::LOW_REF_STEP_MV;
   endfunction

   // Code actually shown; the off pulse forces the default at once
   function automatic logic [3:0] shown(input logic clear, input logic [3:0] code);
      shown = clear ? ecsd_pkg::DEFAULT_CODE : code;
   endfunction

   // Edge and state decode
   wire rise = en_set_in && !en_set_d;
   wire is_off = (state == ecsd_pkg::ECSD_OFF);
   wire is_count = (state == ecsd_pkg::ECSD_COUNT);

   // A rising edge that meets the off pulse still wins: the pin is high
   // again, so the device must come up rather than drop the first edge
   wire go_off = off_hit && !rise; // [RQ8]
   wire on_next = rise || (!is_off && !off_hit); // [RQ14]

   // Extra edges past 16 hold the top code rather than wrapping
   wire at_top = (edge_count == ecsd_pkg::MAX_CODE);
   wire [3:0] next_count_step = at_top ? edge_count : 4'(edge_count + 4'h1); // [RQ5]
   // Only an edge inside a burst steps; the first edge starts at code 0
   wire step_ok = rise && is_count && !off_hit;
   wire latch_ok = latch_hit && is_count;

   // Output selection
   wire [3:0] code_now = shown(off_hit, setpoint);
   wire [10:0] low_mv = code_to_mv(shown(off_hit, setpoint));
   wire [10:0] next_ref_mv = ref_sel_in ? ecsd_pkg::HIGH_REF_MV : low_mv; // [RQ11]
   wire next_high_en = on_next && ref_sel_in; // [RQ1] [RQ3]
   wire next_low_en = on_next && !ref_sel_in; // [RQ2] [RQ3]

   // Timers restart whenever their level breaks, so each edge re-arms the latch
   wire latch_run = en_set_in && is_count;
   wire off_run = !en_set_in && !is_off;

   // Latch timeout runs while the pin is high after an edge
   ecsd_timer #(.LIMIT(LATCH_CYCLES), .W(ecsd_pkg::TIMER_W)) u_latch_timer ( // [RQ13]
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .run_in(latch_run),
      .expired_out(latch_hit)
   );

   // Off timeout runs while the pin is low and the device is on
   ecsd_timer #(.LIMIT(OFF_CYCLES), .W(ecsd_pkg::TIMER_W)) u_off_timer ( // [RQ13]
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .run_in(off_run),
      .expired_out(off_hit)
   );

   // Control flow
   always_comb
   begin
      next_state = state;
      case (state)
         ecsd_pkg::ECSD_OFF:
         begin
            if (rise)
               next_state = ecsd_pkg::ECSD_COUNT; // [RQ14]
         end
         ecsd_pkg::ECSD_COUNT:
         begin
            if (go_off)
               next_state = ecsd_pkg::ECSD_OFF; // [RQ8]
            else if (latch_hit)
               next_state = ecsd_pkg::ECSD_RUN; // [RQ7]
         end
         ecsd_pkg::ECSD_RUN, ecsd_pkg::ECSD_WAIT_LOW:
         begin
            if (rise)
               next_state = ecsd_pkg::ECSD_COUNT;
            else if (off_hit)
               next_state = ecsd_pkg::ECSD_OFF; // [RQ8]
         end
         default:
            next_state = ecsd_pkg::ECSD_OFF;
      endcase
   end

   // Burst count and applied code
   always_comb
   begin
      next_edge_count = edge_count;
      if (step_ok)
         next_edge_count = next_count_step; // [RQ5]
      else if (rise || off_hit)
         next_edge_count = ecsd_pkg::DEFAULT_CODE; // [RQ14]
      next_setpoint = setpoint;
      if (off_hit)
         next_setpoint = ecsd_pkg::DEFAULT_CODE; // [RQ9]
      else if (latch_ok)
         next_setpoint = edge_count; // [RQ7]
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         state <= ecsd_pkg::ECSD_OFF;
      else
         state <= next_state;
   end

   // A pin held high through reset reads as a first edge on release
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         en_set_d <= 1'b0;
      else
         en_set_d <= en_set_in;
   end

   // The count is scratch: it only matters once the latch timer expires
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         edge_count <= ecsd_pkg::DEFAULT_CODE;
      else
         edge_count <= next_edge_count;
   end

   // The setpoint survives idle periods; only the off pulse or a new latch moves it
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         setpoint <= ecsd_pkg::DEFAULT_CODE; // [RQ10]
      else
         setpoint <= next_setpoint;
   end

   // Registered outputs; the select pin is followed every cycle
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         enabled_out <= 1'b0;
         high_feedback_ref_en_out <= 1'b0;
         low_feedback_ref_en_out <= 1'b0;
      end
      else
      begin
         enabled_out <= on_next;
         high_feedback_ref_en_out <= next_high_en; // [RQ1] [RQ3]
         low_feedback_ref_en_out <= next_low_en; // [RQ2] [RQ3]
      end
   end

   // Code and level carry their default values through reset
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         setpoint_code_out <= ecsd_pkg::DEFAULT_CODE; // [RQ10]
         ref_mv_out <= ecsd_pkg::LOW_REF_BASE_MV; // [RQ10]
      end
      else
      begin
         setpoint_code_out <= code_now; // [RQ9]
         ref_mv_out <= next_ref_mv; // [RQ11]
      end
   end
endmodule
`default_nettype wire

// ### sim/ecsd_checker.sv
/* Port checker for ecsd_decoder.
   Assumes it is bound to the decoder and that the timeouts come from its parameters. */
`timescale 1ns/1ps
`default_nettype none
module ecsd_checker #(
   parameter int LATCH_CYCLES = 50000,
   parameter int OFF_CYCLES = 50000
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Pins from the host
   input wire logic en_set_in,
   input wire logic ref_sel_in,
   // Decoder outputs
   input wire logic enabled_out,
   input wire logic high_feedback_ref_en_out,
   input wire logic low_feedback_ref_en_out,
   input wire logic [3:0] setpoint_code_out,
   input wire logic [10:0] ref_mv_out
);
   int lo_cnt;
   always_ff @(posedge clk_in)
      lo_cnt <= (sys_rst_in || en_set_in) ? 0 : lo_cnt + 1;
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   a_high_ref_mv: assert property (high_feedback_ref_en_out |-> ref_mv_out == ecsd_pkg::HIGH_REF_MV)
      else $error("high ref level");
   a_sel_follow: assert property (enabled_out && $past(enabled_out) |->
      high_feedback_ref_en_out == $past(ref_sel_in) && low_feedback_ref_en_out != $past(ref_sel_in))
      else $error("select not followed");
   a_off_quiet: assert property (!enabled_out |-> !high_feedback_ref_en_out && !low_feedback_ref_en_out)
      else $error("ref on while off");
   a_off_timeout: assert property (lo_cnt == OFF_CYCLES + 4 |-> !enabled_out && setpoint_code_out == 4'h0)
      else $error("off timeout");
   a_rise_enables: assert property ($rose(en_set_in) |-> ##[1:2] enabled_out)
      else $error("rise did not enable");
   a_reset_default: assert property ($fell(sys_rst_in) |-> setpoint_code_out == 4'h0 && ref_mv_out == 11'h258)
      else $error("reset level");
   a_low_ref_mv: assert property (low_feedback_ref_en_out && $stable(setpoint_code_out) &&
      $stable(low_feedback_ref_en_out) |-> ref_mv_out == 11'h258 + 11'h028 * setpoint_code_out)
      else $error("low ref level");
   a_code_latch: assert property ($changed(setpoint_code_out) |-> en_set_in || lo_cnt >= OFF_CYCLES - 2)
      else $error("code changed early");
endmodule
bind ecsd_decoder ecsd_checker #(.LATCH_CYCLES(LATCH_CYCLES), .OFF_CYCLES(OFF_CYCLES)) u_ecsd_checker (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .en_set_in(en_set_in), .ref_sel_in(ref_sel_in),
   .enabled_out(enabled_out), .high_feedback_ref_en_out(high_feedback_ref_en_out),
   .low_feedback_ref_en_out(low_feedback_ref_en_out), .setpoint_code_out(setpoint_code_out), .ref_mv_out(ref_mv_out));
`default_nettype wire

// ### sim/ecsd_host.sv
/* Host model: drives the enable/set pin and the select pin.
   Assumes its tasks are called at falling clock edges. */
`timescale 1ns/1ps
`default_nettype none
module ecsd_host (
   // Clock
   input wire logic clk_in,
   // Pins to the decoder
   output logic en_set_out = 1'b0,
   output logic ref_sel_out = 1'b0
);
   task automatic hold(input logic lvl, input int n);
      en_set_out = lvl;
      repeat (n) @(negedge clk_in);
   endtask
   // 50 low plus 50 high cycles: one edge per microsecond at most
   task automatic burst(input int n);
      ref_sel_out = 1'b0;
      repeat (n)
      begin
         hold(1'b0, 50);
         hold(1'b1, 50);
      end
   endtask
endmodule
`default_nettype wire

// ### sim/test_edge_count_setpoint_decoder.sv
/* Self-checking bench for ecsd_decoder with the host model.
   Assumes both timeouts are shortened to LAT cycles. */
`timescale 1ns/1ps
`default_nettype none
module test_edge_count_setpoint_decoder;
   localparam int LAT = 120;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic en_set, ref_sel, enabled, hi_en, lo_en;
   logic [3:0] code, want;
   logic [10:0] mv;
   logic [17:0] notes[$];
   logic [31:0] lfsr = 32'h7a694705;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   initial
      forever #5 clk_in = ~clk_in;
   ecsd_host u_ecsd_host (.clk_in(clk_in), .en_set_out(en_set), .ref_sel_out(ref_sel));
   ecsd_decoder #(.LATCH_CYCLES(LAT), .OFF_CYCLES(LAT)) u_ecsd_decoder (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .en_set_in(en_set), .ref_sel_in(ref_sel), .enabled_out(enabled), .high_feedback_ref_en_out(hi_en),
      .low_feedback_ref_en_out(lo_en), .setpoint_code_out(code), .ref_mv_out(mv));
   // Note: enable, high ref, low ref, code, millivolts; one spare edge keeps outputs steady for the pop
   task automatic expect_out(input logic e, input logic s, input logic [3:0] c);
      notes.push_back({e, e & s, e & ~s, c, s ? 11'h4b0 : 11'(11'h258 + 11'h028 * c)});
      @(negedge clk_in);
   endtask
   task automatic compare(input logic [17:0] exp_v, input logic [17:0] got);
      tests_run++;
      if (got !== exp_v)
      begin
         miscompares++;
         $display("[FAIL] %0t exp %h got %h", $time, exp_v, got);
      end
   endtask
   task automatic complete_run();
      if (miscompares == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(negedge clk_in)
   begin
      cycles++;
      if (notes.size() > 0)
         compare(notes.pop_front(), {enabled, hi_en, lo_en, code, mv});
      if (cycles == 40000)
      begin
         miscompares++;
         complete_run();
      end
   end
   initial
   begin
      repeat (4) @(negedge clk_in);
      sys_rst_in = 1'b0;
      u_ecsd_host.hold(1'b0, 3);
      expect_out(1'b0, 1'b0, 4'h0);
      u_ecsd_host.hold(1'b1, LAT + 8);
      expect_out(1'b1, 1'b0, 4'h0);
      for (int i = 0; i < 8; i++)
      begin
         n = (i < 2) ? 16 + i : lfsr % 16 + 1;
         want = (n > 16) ? 4'hf : 4'(n - 1);
         lfsr = lfsr_next(lfsr);
         u_ecsd_host.burst(n);
         u_ecsd_host.hold(1'b1, LAT + 8);
         expect_out(1'b1, 1'b0, want);
         u_ecsd_host.ref_sel_out = 1'b1;
         repeat (3) @(negedge clk_in);
         expect_out(1'b1, 1'b1, want);
      end
      u_ecsd_host.burst(1);
      u_ecsd_host.hold(1'b0, LAT + 8);
      expect_out(1'b0, 1'b0, 4'h0);
      u_ecsd_host.hold(1'b1, 3);
      expect_out(1'b1, 1'b0, 4'h0);
      u_ecsd_host.hold(1'b1, LAT + 8);
      expect_out(1'b1, 1'b0, 4'h0);
      // Let the watcher take the last note before the verdict
      repeat (2) @(negedge clk_in);
      complete_run();
   end
endmodule
`default_nettype wire
